/* rtl/brs_supervisor.sv */
// Digital supervisor for a step-down regulator with APB register access
`timescale 1ns/100ps
// Operation
// - Hold a signed nine-bit offset, plus or minus 25 percent, 0.1 percent steps.
// - Step applied offset by one code per slew tick toward the selected target.
// - Pick nominal, high or low offset register by the margin input.
// - With write protect high, ignore writes to the three offset registers.
// - Accept five thirteen-bit telemetry results, refreshed at 25 Hz while running.
// - Keep per-channel peak register holding highest result since restart.
// - Restart peaks on clear-all command, peak register write or master run low.
// - Regulate to track input while below reference, else to the reference.
// - Run discontinuous during start-up while track is below reference.
// - Power-good window from limit input; default ten percent when tied high.
// - Delay power-good rise by 200 us to 25 ms, chosen by select input.
// - Blank power-good fall for sixteen switching cycles.
// - Force continuous mode on over or undervoltage, except during start-up.
// - Master run low turns switcher, telemetry and serial enable off and overrides standby.
// - Master shutdown returns all host registers to power-on values.
// - Standby stops switching; refresh only vin, vout and temperature at 1 Hz.
// - Rising on bit leaving standby clears latched faults and alert.
// - Standby keeps host registers; restart returns to last selected offset.
// - Switcher enabled only with master run, standby run and on bit all set.
// - On bit set at power-on and on each exit from master shutdown.
// - Detected external clock takes over the frequency tracking loop.
module brs_supervisor (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_run_in,
    input wire logic standby_run_in,
    input wire logic write_protect_in,
    input wire logic margin_high_in,
    input wire logic margin_low_in,
    input wire logic slew_capacitor_in,
    input wire logic track_below_ref_in,
    input wire logic window_limit_tied_in,
    input wire logic [7:0] window_limit_in,
    input wire logic [7:0] good_delay_select_in,
    input wire logic in_window_in,
    input wire logic overvoltage_in,
    input wire logic undervoltage_in,
    input wire logic switch_cycle_in,
    input wire logic ext_clock_detect_in,
    input wire logic [brs_pkg::FAULT_W-1:0] fault_event_in,
    input wire brs_pkg::brs_sample_s sample_in,
    output logic signed [8:0] ref_offset_out,
    output logic [7:0] window_limit_out,
    output brs_pkg::brs_switch_s switch_out,
    output logic power_good_out,
    output logic alert_out,
    output logic adc_convert_out,
    output logic [4:0] adc_channel_mask_out,
    output logic serial_enable_out
);
    import brs_pkg::*;

    // Pin synchronisers, two stages each
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] pin_s1_q;
    logic [NSYNC-1:0] pin_s2_q;
    logic mrun, srun, wp, m_hi, m_lo, slew_tick, trk_below, inwin, swc, ovuv, extclk;
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else begin
            pin_s1_q <= {ext_clock_detect_in, overvoltage_in | undervoltage_in, switch_cycle_in,
                         in_window_in, track_below_ref_in, slew_capacitor_in, margin_low_in,
                         margin_high_in, write_protect_in, standby_run_in};
            pin_s2_q <= pin_s1_q;
        end
    end
    logic [1:0] mrun_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            mrun_q <= 2'h0;
        end else begin
            mrun_q <= {mrun_q[0], master_run_in};
        end
    end
    assign mrun = mrun_q[1];
    assign {extclk, ovuv, swc, inwin, trk_below, slew_tick, m_lo, m_hi, wp, srun} = pin_s2_q;

    // Edge history for slew pace and switching cycle count
    logic slew_prev_q, swc_prev_q, inwin_prev_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            slew_prev_q <= 1'b0;
            swc_prev_q <= 1'b0;
            inwin_prev_q <= 1'b0;
        end else begin
            slew_prev_q <= slew_tick;
            swc_prev_q <= swc;
            inwin_prev_q <= inwin;
        end
    end
    logic slew_edge, swc_edge, win_change;
    assign slew_edge = slew_tick & ~slew_prev_q;
    assign swc_edge = swc & ~swc_prev_q;
    assign win_change = inwin ^ inwin_prev_q;

    // Register storage
    logic [31:0] ctrl_q;
    logic signed [8:0] nom_q, high_q, low_q;
    logic [FAULT_W-1:0] fault_q;
    logic [TLM_W-1:0] tlm_q [NUM_TLM];
    logic [TLM_W-1:0] peak_q [NUM_TLM];
    logic [NUM_TLM-1:0] peak_fresh_q;
    logic on_prev_q;
    brs_mode_e mode;

    // Bus access decode; every access completes in its first access cycle
    logic wr_en, rd_en;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    logic [2:0] tlm_idx;
    assign tlm_idx = paddr[4:2];
    logic hit_tlm, hit_peak;
    assign hit_tlm = (paddr >= ADDR_TLM_BASE) && (paddr < ADDR_TLM_BASE + 8'h14);
    assign hit_peak = (paddr >= ADDR_PEAK_BASE) && (paddr < ADDR_PEAK_BASE + 8'h14);
    logic ofs_wr_ok;
    assign ofs_wr_ok = ~wp;

    // Mode decode; master shutdown overrides standby
    always_comb begin
        if (!mrun) begin
            mode = BRS_SHUTDOWN;
        end else if (srun && ctrl_q[CTRL_ON_BIT]) begin
            mode = BRS_RUN;
        end else begin
            mode = BRS_STANDBY;
        end
    end

    // Control register; on bit set at power-on and shutdown
    always_ff @(posedge clock) begin
        if (srst || !mrun) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl_q <= {31'h0, pwdata[CTRL_ON_BIT]};
        end
    end

    // Offset registers, held through standby, cleared by shutdown
    always_ff @(posedge clock) begin
        if (srst || !mrun) begin
            nom_q <= 9'sh000;
            high_q <= 9'sh000;
            low_q <= 9'sh000;
        end else if (wr_en && ofs_wr_ok) begin
            if (paddr == ADDR_NOM) begin
                nom_q <= pwdata[8:0];
            end else if (paddr == ADDR_HIGH) begin
                high_q <= pwdata[8:0];
            end else if (paddr == ADDR_LOW) begin
                low_q <= pwdata[8:0];
            end
        end
    end

    // Margin select; both levels at once counts as open
    logic signed [8:0] target;
    always_comb begin
        if (m_hi && !m_lo) begin
            target = high_q;
        end else if (m_lo && !m_hi) begin
            target = low_q;
        end else begin
            target = nom_q;
        end
    end
    logic signed [8:0] target_clip;
    always_comb begin
        if (target > OFS_MAX) begin
            target_clip = OFS_MAX;
        end else if (target < OFS_MIN) begin
            target_clip = OFS_MIN;
        end else begin
            target_clip = target;
        end
    end

    // Applied offset walks one code per slew edge; it holds through standby
    logic signed [8:0] applied_q;
    logic slewing;
    assign slewing = applied_q != target_clip;
    always_ff @(posedge clock) begin
        if (srst || !mrun) begin
            applied_q <= 9'sh000;
        end else if (slew_edge && slewing) begin
            if (applied_q < target_clip) begin
                applied_q <= applied_q + 9'sh001;
            end else begin
                applied_q <= applied_q - 9'sh001;
            end
        end
    end

    // Refresh scheduler: 25 Hz all channels running, 1 Hz three in standby
    logic [CNT_W-1:0] refresh_cnt_q;
    logic [CNT_W-1:0] refresh_lim;
    assign refresh_lim = (mode == BRS_RUN) ? CNT_W'(RUN_REFRESH_CYC - 1)
                                           : CNT_W'(STBY_REFRESH_CYC - 1);
    logic [4:0] chan_mask;
    assign chan_mask = (mode == BRS_RUN) ? 5'h1f : 5'h13;
    always_ff @(posedge clock) begin
        if (srst || mode == BRS_SHUTDOWN) begin
            refresh_cnt_q <= '0;
            adc_convert_out <= 1'b0;
        end else if (refresh_cnt_q >= refresh_lim) begin
            refresh_cnt_q <= '0;
            adc_convert_out <= 1'b1;
        end else begin
            refresh_cnt_q <= refresh_cnt_q + 32'h1;
            adc_convert_out <= 1'b0;
        end
    end

    // Results and peaks per channel; masked channels keep last value
    logic clear_all;
    assign clear_all = wr_en && paddr == ADDR_CLEAR_PEAKS;
    for (genvar i = 0; i < NUM_TLM; i++) begin : g_tlm
        logic take, peak_wr;
        assign take = sample_in.valid && sample_in.channel == 3'(i) && chan_mask[i]
                      && mode != BRS_SHUTDOWN;
        assign peak_wr = wr_en && hit_peak && tlm_idx == 3'(i);
        always_ff @(posedge clock) begin
            if (srst || !mrun) begin
                tlm_q[i] <= '0;
            end else if (take) begin
                tlm_q[i] <= sample_in.value;
            end
        end
        always_ff @(posedge clock) begin
            if (srst || !mrun) begin
                peak_q[i] <= '0;
                peak_fresh_q[i] <= 1'b1;
            end else if (clear_all || peak_wr) begin
                // A result arriving with the restart opens the new peak, so it is not lost
                peak_q[i] <= take ? sample_in.value : '0;
                peak_fresh_q[i] <= !take;
            end else if (take && (peak_fresh_q[i] || sample_in.value > peak_q[i])) begin
                peak_q[i] <= sample_in.value;
                peak_fresh_q[i] <= 1'b0;
            end
        end
    end

    // Latched faults; events win over clears, rising on bit clears all
    always_ff @(posedge clock) begin
        if (srst || !mrun) begin
            fault_q <= '0;
            on_prev_q <= 1'b1;
        end else begin
            on_prev_q <= ctrl_q[CTRL_ON_BIT];
            if (ctrl_q[CTRL_ON_BIT] && !on_prev_q) begin
                fault_q <= fault_event_in;
            end else if (wr_en && paddr == ADDR_FAULT) begin
                fault_q <= (fault_q & ~pwdata[FAULT_W-1:0]) | fault_event_in;
            end else begin
                fault_q <= fault_q | fault_event_in;
            end
        end
    end

    // Power-good rise delay from select input, scaled across its range
    logic [CNT_W-1:0] delay_cyc;
    assign delay_cyc = CNT_W'(PG_DELAY_MIN_CYC) + CNT_W'(
        ((PG_DELAY_MAX_CYC - PG_DELAY_MIN_CYC) / 255) * int'(good_delay_select_in));
    logic [CNT_W-1:0] rise_cnt_q;
    logic [4:0] blank_cnt_q;
    always_ff @(posedge clock) begin
        if (srst || mode != BRS_RUN) begin
            rise_cnt_q <= '0;
            blank_cnt_q <= '0;
            power_good_out <= 1'b0;
        end else if (win_change) begin
            rise_cnt_q <= '0;
            blank_cnt_q <= '0;
        end else if (inwin) begin
            blank_cnt_q <= '0;
            if (rise_cnt_q >= delay_cyc) begin
                power_good_out <= 1'b1;
            end else begin
                rise_cnt_q <= rise_cnt_q + 32'h1;
            end
        end else begin
            rise_cnt_q <= '0;
            if (blank_cnt_q >= 5'(PG_BLANK_SW_CYC)) begin
                power_good_out <= 1'b0;
            end else if (swc_edge) begin
                blank_cnt_q <= blank_cnt_q + 5'h01;
            end
        end
    end

    // Registered pin and switcher outputs
    always_ff @(posedge clock) begin
        if (srst) begin
            ref_offset_out <= 9'sh000;
            window_limit_out <= 8'h00;
            switch_out <= '0;
            alert_out <= 1'b0;
            adc_channel_mask_out <= 5'h00;
            serial_enable_out <= 1'b0;
        end else begin
            ref_offset_out <= applied_q;
            window_limit_out <= window_limit_tied_in ? 8'(PG_DEFAULT_WINDOW_PM)
                                                     : window_limit_in;
            switch_out.enable <= mode == BRS_RUN;
            switch_out.use_track <= trk_below;
            switch_out.discontinuous <= mode == BRS_RUN && trk_below;
            switch_out.forced_continuous <= mode == BRS_RUN && !trk_below
                                            && (ovuv || slewing);
            switch_out.use_ext_clock <= extclk;
            alert_out <= |fault_q;
            adc_channel_mask_out <= (mode == BRS_SHUTDOWN) ? 5'h00 : chan_mask;
            serial_enable_out <= mrun;
        end
    end

    // APB read data and error for unmapped addresses
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable) begin
                if (paddr == ADDR_CTRL) begin
                    prdata <= ctrl_q;
                end else if (paddr == ADDR_NOM) begin
                    prdata <= {{23{nom_q[8]}}, nom_q};
                end else if (paddr == ADDR_HIGH) begin
                    prdata <= {{23{high_q[8]}}, high_q};
                end else if (paddr == ADDR_LOW) begin
                    prdata <= {{23{low_q[8]}}, low_q};
                end else if (paddr == ADDR_APPLIED) begin
                    prdata <= {{23{applied_q[8]}}, applied_q};
                end else if (paddr == ADDR_STATUS) begin
                    prdata <= {26'h0, power_good_out, slewing, 2'(mode), mrun, srun};
                end else if (paddr == ADDR_CLEAR_PEAKS) begin
                    prdata <= 32'h0;
                end else if (paddr == ADDR_FAULT) begin
                    prdata <= {24'h0, fault_q};
                end else if (hit_tlm) begin
                    prdata <= {19'h0, tlm_q[tlm_idx]};
                end else if (hit_peak) begin
                    prdata <= {19'h0, peak_q[tlm_idx]};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
    // Access-phase read strobe is not needed: read data is staged in the setup cycle
    logic unused;
    assign unused = rd_en;
endmodule

/* rtl/brs_pkg.sv */
// Package for the regulator supervisor: register map, fields, timing counts
package brs_pkg;
    // APB register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_NOM = 8'h04;
    localparam logic [7:0] ADDR_HIGH = 8'h08;
    localparam logic [7:0] ADDR_LOW = 8'h0c;
    localparam logic [7:0] ADDR_APPLIED = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_CLEAR_PEAKS = 8'h18;
    localparam logic [7:0] ADDR_FAULT = 8'h1c;
    localparam logic [7:0] ADDR_TLM_BASE = 8'h20;
    localparam logic [7:0] ADDR_PEAK_BASE = 8'h40;
    // Control register fields and reset value
    localparam int CTRL_ON_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // Offset code width and limits (0.1 percent per step)
    localparam int OFS_W = 9;
    localparam logic signed [8:0] OFS_MAX = 9'sd250;
    localparam logic signed [8:0] OFS_MIN = -9'sd250;
    localparam int TLM_W = 13;
    localparam int NUM_TLM = 5;
    localparam int FAULT_W = 8;
    // Telemetry channel indices
    localparam int CH_VIN = 0;
    localparam int CH_VOUT = 1;
    localparam int CH_IIN = 2;
    localparam int CH_IOUT = 3;
    localparam int CH_TEMP = 4;
    // Clock and refresh timing
    localparam int CLK_HZ = 125_000_000;
    localparam int RUN_REFRESH_HZ = 25;
    localparam int STBY_REFRESH_HZ = 1;
    localparam int RUN_REFRESH_CYC = CLK_HZ / RUN_REFRESH_HZ;
    localparam int STBY_REFRESH_CYC = CLK_HZ / STBY_REFRESH_HZ;
    // Power-good timing
    localparam int PG_DELAY_MIN_US = 200;
    localparam int PG_DELAY_MAX_US = 25_000;
    localparam int PG_DELAY_MIN_CYC = (PG_DELAY_MIN_US * (CLK_HZ / 1_000_000));
    localparam int PG_DELAY_MAX_CYC = (PG_DELAY_MAX_US * (CLK_HZ / 1_000_000));
    localparam int PG_BLANK_SW_CYC = 16;
    localparam int PG_DEFAULT_WINDOW_PM = 100;
    localparam int CNT_W = 32;

    // Run mode of the supervisor
    typedef enum logic [1:0] {
        BRS_SHUTDOWN,
        BRS_STANDBY,
        BRS_RUN
    } brs_mode_e;

    // Three-level margin input
    typedef enum logic [1:0] {
        BRS_MARGIN_OPEN,
        BRS_MARGIN_HIGH,
        BRS_MARGIN_LOW
    } brs_margin_e;

    // One converted telemetry sample
    typedef struct packed {
        logic valid;
        logic [2:0] channel;
        logic [12:0] value;
    } brs_sample_s;

    // Switcher control outputs
    typedef struct packed {
        logic enable;
        logic discontinuous;
        logic forced_continuous;
        logic use_track;
        logic use_ext_clock;
    } brs_switch_s;
endpackage

/* testbench/brs_supervisor_asserts.sv */
// Port-level assertions for the regulator supervisor, bound to its top module
`timescale 1ns/100ps
module brs_supervisor_chk (
    input wire logic clock,
    input wire logic srst,
    input wire logic master_run_in,
    input wire logic standby_run_in,
    input wire logic track_below_ref_in,
    input wire logic overvoltage_in,
    input wire logic window_limit_tied_in,
    input wire logic in_window_in,
    input wire logic ext_clock_detect_in,
    input wire logic signed [8:0] ref_offset_out,
    input wire logic [7:0] window_limit_out,
    input wire brs_pkg::brs_switch_s switch_out,
    input wire logic power_good_out,
    input wire logic [4:0] adc_channel_mask_out,
    input wire logic serial_enable_out
);
    import brs_pkg::*;
    // One clock domain; reset silences every check
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    AST_SHUTDOWN_OFF: assert property (
        !master_run_in [*4] |-> !serial_enable_out && !switch_out.enable)
        else $error("outputs live in master shutdown");
    AST_STANDBY_OFF: assert property (!standby_run_in [*6] |-> !switch_out.enable)
        else $error("switcher on with standby run low");
    // Master run held high keeps the shutdown clear off the offset, so only slew steps remain
    AST_SLEW_STEP: assert property (
        master_run_in [*6] ##0 $changed(ref_offset_out)
        |-> ref_offset_out - $past(ref_offset_out) inside {9'sd1, -9'sd1})
        else $error("applied offset jumped by more than one code");
    AST_START_TRACK: assert property (
        (track_below_ref_in && switch_out.enable) [*6]
        |-> switch_out.use_track && switch_out.discontinuous)
        else $error("start-up not tracking in discontinuous mode");
    AST_TRACK_DONE: assert property (
        !track_below_ref_in [*6] |-> !switch_out.use_track && !switch_out.discontinuous)
        else $error("still tracking above the reference");
    AST_FORCED_FAULT: assert property (
        (overvoltage_in && !track_below_ref_in && switch_out.enable) [*6]
        |-> switch_out.forced_continuous)
        else $error("continuous mode not forced on overvoltage");
    AST_EXT_CLOCK: assert property (
        (ext_clock_detect_in && switch_out.enable) [*5] |-> switch_out.use_ext_clock)
        else $error("external clock not taken over");
    AST_WINDOW_DEFAULT: assert property (
        (window_limit_tied_in && serial_enable_out) [*4] |-> window_limit_out == 8'h64)
        else $error("default window not applied");
    // Delay is far longer than 250 cycles, so the window must have held that long
    AST_PG_RISE: assert property (
        $rose(power_good_out) |-> $past(in_window_in, 4) && $past(in_window_in, 250))
        else $error("power good rose without a settled window");
    // Eight cycles hold at most four switching edges, well short of the blanking count
    AST_PG_BLANK: assert property (
        power_good_out && $fell(in_window_in) |-> power_good_out [*8])
        else $error("power good fell inside blanking");
    AST_MASK_RUN: assert property (switch_out.enable [*4] |-> adc_channel_mask_out == 5'h1f)
        else $error("running telemetry mask wrong");
endmodule

bind brs_supervisor brs_supervisor_chk u_brs_supervisor_chk (.*);

/* testbench/brs_board_model.sv */
// Board-side partner: slew and switching pins plus converter results
`timescale 1ns/100ps
module brs_board_model (
    input wire logic clock,
    output logic slew_capacitor_in,
    output logic switch_cycle_in,
    output brs_pkg::brs_sample_s sample_in
);
    import brs_pkg::*;
    // Pins rest low between pulses
    initial begin
        {switch_cycle_in, slew_capacitor_in} = 2'b00;
        sample_in = '0;
    end
    // Pulses last three cycles so the synchroniser cannot miss them; gap sets the pace
    task automatic pulse(input bit sw, input int n, input int gap);
        repeat (n) begin
            {switch_cycle_in, slew_capacitor_in} <= sw ? 2'b10 : 2'b01;
            repeat (3) @(posedge clock);
            {switch_cycle_in, slew_capacitor_in} <= 2'b00;
            repeat (gap) @(posedge clock);
        end
    endtask
    // One result valid for one cycle; the payload is scrambled once released
    task automatic send(input logic [2:0] ch, input logic [12:0] v);
        sample_in <= '{1'b1, ch, v};
        @(posedge clock);
        sample_in <= '{1'b0, ~ch, ~v};
        @(posedge clock);
    endtask
endmodule

/* testbench/tb.sv */
// Self-checking bench for the regulator supervisor over APB
`timescale 1ns/100ps
module tb;
    import brs_pkg::*;
    logic clock, srst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, window_limit_in, good_delay_select_in, window_limit_out;
    logic [31:0] pwdata, prdata, rd;
    logic master_run_in, standby_run_in, write_protect_in, margin_high_in, margin_low_in;
    logic slew_capacitor_in, track_below_ref_in, window_limit_tied_in, in_window_in;
    logic overvoltage_in, undervoltage_in, switch_cycle_in, ext_clock_detect_in;
    logic power_good_out, alert_out, adc_convert_out, serial_enable_out;
    logic [FAULT_W-1:0] fault_event_in;
    logic signed [8:0] ref_offset_out;
    logic [4:0] adc_channel_mask_out;
    brs_sample_s sample_in;
    brs_switch_s switch_out;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    // Margin pins per step, with the applied code expected mid-ramp and at rest
    logic [1:0] pins [3] = '{2'b10, 2'b01, 2'b00};
    logic [31:0] mid [3] = '{32'h8, 32'h2, 32'hffff_fffd};
    logic [31:0] tgt [3] = '{32'ha, 32'hffff_fff6, 32'hffff_fffd};

    brs_supervisor u_brs_supervisor (.*);
    brs_board_model u_brs_board_model (.*);

    // Free-running 125 MHz clock
    initial clock = 1'b0;
    always #4 clock = ~clock;

    // Cycle ceiling cuts a hang short; the power-good delay alone needs 25000
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One APB transfer; a spare edge after release keeps drivers from colliding
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        @(posedge clock);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    initial begin
        {srst, master_run_in, standby_run_in, window_limit_tied_in} = 4'hf;
        {psel, penable, pwrite, write_protect_in, margin_high_in, margin_low_in} = 6'h00;
        {track_below_ref_in, in_window_in, overvoltage_in, undervoltage_in} = 4'h0;
        {paddr, pwdata, window_limit_in, good_delay_select_in} = 56'h0;
        ext_clock_detect_in = 1'b0;
        fault_event_in = '0;
        cyc(5);
        srst <= 1'b0;
        cyc(8);
        rdchk(ADDR_CTRL, CTRL_RESET);
        rdchk(ADDR_NOM, 32'h0);
        $display("test reset values done");
        apb(1'b1, ADDR_NOM, 32'hffff_fffd);
        apb(1'b1, ADDR_HIGH, 32'h0000_000a);
        apb(1'b1, ADDR_LOW, 32'hffff_fff6);
        rdchk(ADDR_NOM, 32'hffff_fffd);
        write_protect_in <= 1'b1;
        cyc(4);
        apb(1'b1, ADDR_HIGH, 32'h0000_0055);
        apb(1'b1, ADDR_NOM, 32'h0000_0055);
        rdchk(ADDR_HIGH, 32'h0000_000a);
        rdchk(ADDR_NOM, 32'hffff_fffd);
        write_protect_in <= 1'b0;
        $display("test offsets and write protect done");
        // Each margin setting: part of the ramp, then the rest of it
        for (int i = 0; i < 3; i++) begin
            {margin_high_in, margin_low_in} <= pins[i];
            cyc(4);
            u_brs_board_model.pulse(1'b0, 8, 2);
            cyc(4);
            chk(32'(ref_offset_out), mid[i]);
            u_brs_board_model.pulse(1'b0, 16, 2);
            rdchk(ADDR_APPLIED, tgt[i]);
        end
        $display("test margin select done");
        u_brs_board_model.send(3'(CH_VIN), 13'h0100);
        u_brs_board_model.send(3'(CH_VIN), 13'h1abc);
        u_brs_board_model.send(3'(CH_VIN), 13'h0200);
        rdchk(ADDR_TLM_BASE, 32'h0200);
        rdchk(ADDR_PEAK_BASE, 32'h1abc);
        apb(1'b1, ADDR_PEAK_BASE, 32'h0);
        u_brs_board_model.send(3'(CH_VIN), 13'h0050);
        rdchk(ADDR_PEAK_BASE, 32'h0050);
        u_brs_board_model.send(3'(CH_IOUT), 13'h0777);
        apb(1'b1, ADDR_CLEAR_PEAKS, 32'h0);
        rdchk(ADDR_PEAK_BASE + 8'h0c, 32'h0);
        apb(1'b0, 8'h60, 32'h0);
        chk(32'(err), 32'h1);
        $display("test telemetry and peaks done");
        fault_event_in <= FAULT_W'(1);
        cyc(1);
        fault_event_in <= '0;
        cyc(3);
        rdchk(ADDR_FAULT, 32'h1);
        chk(32'(alert_out), 32'h1);
        apb(1'b1, ADDR_CTRL, 32'h0);
        cyc(6);
        chk(32'({switch_out.enable, serial_enable_out, adc_channel_mask_out}), 32'h33);
        rdchk(ADDR_STATUS, {28'h0, 2'(BRS_STANDBY), 2'b11});
        rdchk(ADDR_HIGH, 32'h0000_000a);
        apb(1'b1, ADDR_CTRL, 32'h1);
        cyc(4);
        rdchk(ADDR_FAULT, 32'h0);
        chk(32'(alert_out), 32'h0);
        u_brs_board_model.pulse(1'b0, 8, 2);
        cyc(4);
        chk(32'(ref_offset_out), 32'hffff_fffd);
        standby_run_in <= 1'b0;
        cyc(8);
        chk(32'(switch_out.enable), 32'h0);
        standby_run_in <= 1'b1;
        $display("test standby done");
        {track_below_ref_in, overvoltage_in, ext_clock_detect_in} <= 3'b111;
        {window_limit_tied_in, window_limit_in} <= 9'h02a;
        cyc(10);
        chk(32'(switch_out), 32'h1b);
        chk(32'(window_limit_out), 32'h2a);
        track_below_ref_in <= 1'b0;
        cyc(8);
        chk(32'(switch_out), 32'h15);
        {overvoltage_in, ext_clock_detect_in, window_limit_tied_in} <= 3'b001;
        cyc(8);
        chk(32'(switch_out), 32'h10);
        chk(32'(window_limit_out), 32'h64);
        $display("test switcher modes done");
        in_window_in <= 1'b1;
        cyc(24990);
        chk(32'(power_good_out), 32'h0);
        cyc(20);
        chk(32'(power_good_out), 32'h1);
        in_window_in <= 1'b0;
        u_brs_board_model.pulse(1'b1, 15, 2);
        cyc(4);
        chk(32'(power_good_out), 32'h1);
        u_brs_board_model.pulse(1'b1, 2, 2);
        cyc(6);
        chk(32'(power_good_out), 32'h0);
        $display("test power good done");
        apb(1'b1, ADDR_CTRL, 32'h0);
        master_run_in <= 1'b0;
        cyc(6);
        chk(32'({switch_out.enable, serial_enable_out}), 32'h0);
        master_run_in <= 1'b1;
        cyc(6);
        rdchk(ADDR_CTRL, CTRL_RESET);
        rdchk(ADDR_NOM, 32'h0);
        rdchk(ADDR_HIGH, 32'h0);
        rdchk(ADDR_PEAK_BASE, 32'h0);
        $display("test master shutdown done");
        give_verdict();
    end
endmodule
